// file: hw/sbsr_params.svh
// Function
// - Status byte bit 6 summarises the other status byte bits.
// - Status byte returned on status query and on serial poll.
// - Every status bit has a mask bit; mask bit 6 has no effect.
// - Enabled status bit rising 0 to 1 raises a service request.
// - Mask is written by set command and read back by query.
// - Error queue bit set whenever an error entry is pushed.
// - With error bit enabled, each new error entry requests service.
// - Questionable summary set when an enabled questionable event is set.
// - Message available bit set while output queue holds a message.
// - Event summary set when an enabled event status bit is set.
// - Main summary set exactly when some enabled status bit is set.
// - Operation summary set when an enabled operation event is set.
// - A lower summary is the OR of events ANDed with enables.
// - Reading an event register clears it except for events set in the read cycle.
// - Event summary set when an enabled event status bit rises.
`ifndef SBSR_PARAMS_SVH
`define SBSR_PARAMS_SVH

// ----------------------------------------
// Status byte bit positions
// ----------------------------------------
`define SBSR_BIT_ERRQ   2
`define SBSR_BIT_QUES   3
`define SBSR_BIT_MAV    4
`define SBSR_BIT_ESB    5
`define SBSR_BIT_MSS    6
`define SBSR_BIT_OPER   7

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define SBSR_BYTE_W     8
`define SBSR_SCPI_W     16
`define SBSR_ESR_W      8
`define SBSR_MASK_RST   8'h00
`define SBSR_MSS_MASK   8'h40

`endif

// file: hw/sbsr_pkg.sv
package sbsr_pkg;
  typedef logic [7:0] sbsr_byte_t;
  typedef enum logic [1:0] {
    SBSR_RESP_STATUS,
    SBSR_RESP_POLL,
    SBSR_RESP_MASK
  } sbsr_resp_t;
endpackage

// file: hw/sbsr_evt_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sbsr_evt_if #(parameter int W = 16);
  logic [W-1:0] set;
  logic [W-1:0] enable;
  logic         read_clr;
  logic [W-1:0] rdata;
  logic         summary;
  modport dev  (input set, enable, read_clr, output rdata, summary);
  modport user (output set, enable, read_clr, input rdata, summary);
endinterface
`default_nettype wire

// file: hw/sbsr_evt_reg.sv
`timescale 1ns/1ns
`default_nettype none
module sbsr_evt_reg
  import sbsr_pkg::*;
#(
  parameter int W = 16
)(
  input  wire logic clock,
  input  wire logic nrst,
  sbsr_evt_if.dev   ev
);
  logic [W-1:0] ev_reg;

  // ----------------------------------------
  // Event memory, cleared by a read
  // ----------------------------------------
  // A new event in the read cycle survives the clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ev_reg <= '0;
    end else if (ev.read_clr) begin
      ev_reg <= ev.set;
    end else begin
      ev_reg <= ev_reg | ev.set;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ev.rdata <= '0;
    end else if (ev.read_clr) begin
      ev.rdata <= ev_reg;
    end
  end

  assign ev.summary = |(ev_reg & ev.enable);

  a_evt_clear_read: assert property (@(posedge clock) disable iff (!nrst)
    ev.read_clr |=> ((ev_reg & ~$past(ev.set)) == '0))
    else $error("event register not cleared by read");
  a_evt_set_kept: assert property (@(posedge clock) disable iff (!nrst)
    (|ev.set) |=> ((ev_reg & $past(ev.set)) == $past(ev.set)))
    else $error("event lost");
endmodule
`default_nettype wire

// file: hw/sbsr_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "sbsr_params.svh"
module sbsr_top
  import sbsr_pkg::*;
#(
  parameter int SCPI_W = `SBSR_SCPI_W,
  parameter int ESR_W  = `SBSR_ESR_W
)(
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic              status_query,
  input  wire logic              serial_poll,
  input  wire logic              mask_write,
  input  wire logic [7:0]        mask_wdata,
  input  wire logic              mask_query,
  output logic                   resp_valid,
  output logic [7:0]             resp_data,
  input  wire logic              errq_push,
  input  wire logic              errq_nonempty,
  input  wire logic              outq_msg_avail,
  input  wire logic [SCPI_W-1:0] ques_set,
  input  wire logic [SCPI_W-1:0] ques_enable,
  input  wire logic              ques_read,
  output logic [SCPI_W-1:0]      ques_rdata,
  input  wire logic [SCPI_W-1:0] oper_set,
  input  wire logic [SCPI_W-1:0] oper_enable,
  input  wire logic              oper_read,
  output logic [SCPI_W-1:0]      oper_rdata,
  input  wire logic [ESR_W-1:0]  esr_set,
  input  wire logic [ESR_W-1:0]  esr_enable,
  input  wire logic              esr_read,
  output logic [ESR_W-1:0]       esr_rdata,
  output logic                   srq_pulse,
  output logic [7:0]             status_byte
);
  sbsr_byte_t mask_reg;
  sbsr_byte_t sts_prev_reg;
  sbsr_byte_t sts_now;
  sbsr_byte_t sts_low;
  sbsr_byte_t rise;
  logic       mss;
  logic       srq_next;
  logic       resp_any;
  sbsr_resp_t resp_sel;

  // ----------------------------------------
  // Lower event registers
  // ----------------------------------------
  sbsr_evt_if #(.W(SCPI_W)) ques_if ();
  sbsr_evt_if #(.W(SCPI_W)) oper_if ();
  sbsr_evt_if #(.W(ESR_W))  esr_if ();

  assign ques_if.set      = ques_set;
  assign ques_if.enable   = ques_enable;
  assign ques_if.read_clr = ques_read;
  assign ques_rdata       = ques_if.rdata;
  assign oper_if.set      = oper_set;
  assign oper_if.enable   = oper_enable;
  assign oper_if.read_clr = oper_read;
  assign oper_rdata       = oper_if.rdata;
  assign esr_if.set       = esr_set;
  assign esr_if.enable    = esr_enable;
  assign esr_if.read_clr  = esr_read;
  assign esr_rdata        = esr_if.rdata;

  sbsr_evt_reg #(.W(SCPI_W)) u_ques (
    .clock (clock),
    .nrst  (nrst),
    .ev    (ques_if)
  );
  sbsr_evt_reg #(.W(SCPI_W)) u_oper (
    .clock (clock),
    .nrst  (nrst),
    .ev    (oper_if)
  );
  sbsr_evt_reg #(.W(ESR_W)) u_esr (
    .clock (clock),
    .nrst  (nrst),
    .ev    (esr_if)
  );

  // ----------------------------------------
  // Status byte assembly
  // ----------------------------------------
  // Push counted in its own cycle so the bit never lags the entry
  always_comb begin
    sts_low                 = '0;
    sts_low[`SBSR_BIT_ERRQ] = errq_nonempty | errq_push;
    sts_low[`SBSR_BIT_QUES] = ques_if.summary;
    sts_low[`SBSR_BIT_MAV]  = outq_msg_avail;
    sts_low[`SBSR_BIT_ESB]  = esr_if.summary;
    sts_low[`SBSR_BIT_OPER] = oper_if.summary;
  end

  // Main summary looks at every bit but its own
  assign mss = |(sts_low & mask_reg & ~`SBSR_MSS_MASK);

  always_comb begin
    sts_now                = sts_low;
    sts_now[`SBSR_BIT_MSS] = mss;
  end

  assign status_byte = sts_prev_reg;

  // ----------------------------------------
  // Service request enable mask
  // ----------------------------------------
  // Bit 6 is stored as zero so it reads back zero and never gates anything
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mask_reg <= `SBSR_MASK_RST;
    end else if (mask_write) begin
      mask_reg <= mask_wdata & ~`SBSR_MSS_MASK;
    end
  end

  // ----------------------------------------
  // Service request generation
  // ----------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sts_prev_reg <= '0;
    end else begin
      sts_prev_reg <= sts_now;
    end
  end

  assign rise = sts_now & ~sts_prev_reg & mask_reg & ~`SBSR_MSS_MASK;

  // Each error entry requests service even while the bit already stands
  assign srq_next = (|rise) || (errq_push && mask_reg[`SBSR_BIT_ERRQ]);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      srq_pulse <= 1'b0;
    end else begin
      srq_pulse <= srq_next;
    end
  end

  // ----------------------------------------
  // Query and serial poll answers
  // ----------------------------------------
  // One answer per cycle: status query, then poll, then mask query
  assign resp_any = status_query | serial_poll | mask_query;

  always_comb begin
    if (status_query) begin
      resp_sel = SBSR_RESP_STATUS;
    end else if (serial_poll) begin
      resp_sel = SBSR_RESP_POLL;
    end else begin
      resp_sel = SBSR_RESP_MASK;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      resp_valid <= 1'b0;
    end else begin
      resp_valid <= resp_any;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      resp_data <= '0;
    end else if (resp_any) begin
      unique case (resp_sel)
        SBSR_RESP_STATUS: resp_data <= sts_now;
        SBSR_RESP_POLL:   resp_data <= sts_now;
        SBSR_RESP_MASK: resp_data <= mask_reg;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_mask_set;
    mask_write && !status_query && !serial_poll && !mask_query;
  endsequence

  sequence s_mask_ask;
    mask_query && !status_query && !serial_poll && !mask_write;
  endsequence

  a_status_query_ans: assert property (@(posedge clock) disable iff (!nrst)
    status_query |=> resp_valid && resp_data == $past(sts_now))
    else $error("status query answer wrong");
  a_serial_poll_ans: assert property (@(posedge clock) disable iff (!nrst)
    (serial_poll && !status_query) |=> resp_valid && resp_data == $past(sts_now))
    else $error("serial poll answer wrong");
  // Write and query are checked apart, since a controller rarely sends them in the same cycle
  a_mask_store: assert property (@(posedge clock) disable iff (!nrst)
    s_mask_set |=> mask_reg == ($past(mask_wdata) & 8'hbf))
    else $error("mask write not stored");
  a_mask_read_back: assert property (@(posedge clock) disable iff (!nrst)
    s_mask_ask |=> resp_valid && resp_data == $past(mask_reg))
    else $error("mask readback wrong");
  a_mask_bit6_dead: assert property (@(posedge clock) disable iff (!nrst)
    mask_write |=> !mask_reg[6] && !rise[6])
    else $error("mask bit 6 active");
  a_srq_on_rise: assert property (@(posedge clock) disable iff (!nrst)
    (|(sts_low & ~sts_prev_reg & mask_reg)) |=> srq_pulse)
    else $error("missed service request");
  a_srq_cause: assert property (@(posedge clock) disable iff (!nrst)
    srq_pulse |-> $past(|rise || (errq_push && mask_reg[2])))
    else $error("service request without cause");
  a_errq_each_push: assert property (@(posedge clock) disable iff (!nrst)
    (errq_push && mask_reg[2]) |=> srq_pulse)
    else $error("error entry gave no request");
  a_errq_bit_set: assert property (@(posedge clock) disable iff (!nrst)
    errq_push |=> status_byte[2])
    else $error("error bit not set");
  a_mss_summary: assert property (@(posedge clock) disable iff (!nrst)
    ##1 status_byte[6] == $past(|(sts_low & mask_reg & 8'hbf)))
    else $error("main summary wrong");
  a_mav_follow: assert property (@(posedge clock) disable iff (!nrst)
    outq_msg_avail |=> status_byte[4])
    else $error("message bit missing");
  a_ques_summary: assert property (@(posedge clock) disable iff (!nrst)
    $rose(|(ques_set & ques_enable)) && !ques_read ##1 1'b1 |=> status_byte[3])
    else $error("questionable summary missing");
  a_oper_summary: assert property (@(posedge clock) disable iff (!nrst)
    (|(oper_set & oper_enable)) && !oper_read ##1 !oper_read |=> status_byte[7])
    else $error("operation summary missing");
  a_esb_summary: assert property (@(posedge clock) disable iff (!nrst)
    (|(esr_set & esr_enable)) ##1 !esr_read |=> status_byte[5])
    else $error("event summary missing");
endmodule
`default_nettype wire

// file: test/sbsr_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module sbsr_ctrl_model
  import sbsr_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resp_valid,
  input  wire logic [7:0] resp_data,
  output logic            status_query,
  output logic            serial_poll,
  output logic            mask_write,
  output logic [7:0]      mask_wdata,
  output logic            mask_query
);
  initial begin
    {status_query, serial_poll, mask_write, mask_query} = 4'h0;
    mask_wdata = 8'h00;
  end

  // ----------------------------------------
  // Command issue: 0 status, 1 poll, 2 mask query, 3 mask write
  // ----------------------------------------
  task automatic send(input int kind, input logic [7:0] d, output logic [7:0] got);
    @(negedge clock);
    status_query = (kind == 0);
    serial_poll  = (kind == 1);
    mask_query   = (kind == 2);
    mask_write   = (kind == 3);
    mask_wdata   = d;
    @(negedge clock);
    // The answer strobe stands only in the cycle after the command edge
    got = (resp_valid === 1'b1) ? resp_data : 8'hee;
    {status_query, serial_poll, mask_write, mask_query} = 4'h0;
    // Released data is not left looking valid
    mask_wdata = ~d;
    @(negedge clock);
  endtask
endmodule
`default_nettype wire

// file: test/status_byte_service_request_tb.sv
`timescale 1ns/1ns
`default_nettype none
module status_byte_service_request_tb;
  logic        clock, nrst, rv, errq_push, errq_nonempty, outq_msg_avail;
  logic        sq, sp, mw, mq, ques_read, oper_read, esr_read, srq_pulse;
  logic [7:0]  rd, wd, esr_set, esr_enable, esr_rdata, status_byte, g;
  logic [15:0] ques_set, ques_enable, ques_rdata, oper_set, oper_enable, oper_rdata;
  int          miscompares, n_tests, srq_cnt;
  int          bits[5] = '{3, 7, 5, 2, 4};

  sbsr_top sbsr_top_i (.clock(clock), .nrst(nrst), .status_query(sq), .serial_poll(sp),
    .mask_write(mw), .mask_wdata(wd), .mask_query(mq), .resp_valid(rv), .resp_data(rd),
    .errq_push(errq_push), .errq_nonempty(errq_nonempty), .outq_msg_avail(outq_msg_avail),
    .ques_set(ques_set), .ques_enable(ques_enable), .ques_read(ques_read),
    .ques_rdata(ques_rdata), .oper_set(oper_set), .oper_enable(oper_enable),
    .oper_read(oper_read), .oper_rdata(oper_rdata), .esr_set(esr_set),
    .esr_enable(esr_enable), .esr_read(esr_read), .esr_rdata(esr_rdata),
    .srq_pulse(srq_pulse), .status_byte(status_byte));
  sbsr_ctrl_model sbsr_ctrl_model_i (.clock(clock), .resp_valid(rv), .resp_data(rd),
    .status_query(sq), .serial_poll(sp), .mask_write(mw), .mask_wdata(wd), .mask_query(mq));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  always @(posedge clock) begin
    if (srq_pulse === 1'b1) srq_cnt++;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------
  // Source stimulus: 0 ques, 1 oper, 2 esr, 3 error queue, 4 output queue
  // ----------------------------------------
  task automatic raise(input int src);
    @(negedge clock);
    srq_cnt = 0;
    case (src)
      0: ques_set = 16'h0001;
      1: oper_set = 16'h0001;
      2: esr_set = 8'h01;
      3: {errq_push, errq_nonempty} = 2'b11;
      default: outq_msg_avail = 1'b1;
    endcase
    @(negedge clock);
    {ques_set, oper_set, esr_set, errq_push} = '0;
    repeat (3) @(negedge clock);
  endtask

  task automatic lower(input int src);
    @(negedge clock);
    case (src)
      0: ques_read = 1'b1;
      1: oper_read = 1'b1;
      2: esr_read = 1'b1;
      3: errq_nonempty = 1'b0;
      default: outq_msg_avail = 1'b0;
    endcase
    @(negedge clock);
    {ques_read, oper_read, esr_read} = 3'b000;
    // Read data lands the cycle after the read pulse and holds
    if (src < 3) check("rdata", (src == 0) ? ques_rdata : (src == 1) ? oper_rdata :
      {8'h00, esr_rdata}, 16'h0001);
    repeat (2) @(negedge clock);
  endtask

  initial begin
    {nrst, errq_push, errq_nonempty, outq_msg_avail, ques_read, oper_read, esr_read} = '0;
    {ques_set, oper_set, esr_set} = '0;
    {ques_enable, oper_enable, esr_enable} = '1;
    miscompares = 0;
    n_tests = 0;
    srq_cnt = 0;
    repeat (3) @(negedge clock);
    nrst = 1'b1;
    check("status_byte", status_byte, 8'h00);
    sbsr_ctrl_model_i.send(2, 8'h00, g);
    check("mask reset", g, 8'h00);
    sbsr_ctrl_model_i.send(3, 8'hff, g);
    check("write answer", g, 8'hee);
    sbsr_ctrl_model_i.send(2, 8'h00, g);
    check("mask", g, 8'hbf);
    for (int s = 0; s < 5; s++) begin
      raise(s);
      check("srq", 16'(srq_cnt), 16'h0001);
      check("status_byte", status_byte, 8'h40 | (8'h01 << bits[s]));
      sbsr_ctrl_model_i.send(0, 8'h00, g);
      check("status query", g, 8'h40 | (8'h01 << bits[s]));
      sbsr_ctrl_model_i.send(1, 8'h00, g);
      check("poll", g, 8'h40 | (8'h01 << bits[s]));
      // A second error entry requests service although the bit is already up
      if (s == 3) raise(3);
      if (s == 3) check("srq again", 16'(srq_cnt), 16'h0001);
      lower(s);
      sbsr_ctrl_model_i.send(0, 8'h00, g);
      check("status cleared", g, 8'h00);
    end
    ques_enable = 16'hfffe;
    raise(0);
    sbsr_ctrl_model_i.send(0, 8'h00, g);
    check("ques disabled", g, 8'h00);
    lower(0);
    ques_enable = '1;
    sbsr_ctrl_model_i.send(3, 8'h00, g);
    raise(0);
    check("srq masked", 16'(srq_cnt), 16'h0000);
    sbsr_ctrl_model_i.send(0, 8'h00, g);
    check("no main summary", g, 8'h08);
    summarize();
  end

  initial begin
    // About fifteen times the length of the sequence above
    repeat (2000) @(posedge clock);
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
